// *** core/tsr_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsr_regs (
   input  wire logic        i_core_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_scl,
   input  wire logic        i_sda_i,
   input  wire logic [2:0]  i_strap_address_pins,
   input  wire logic        i_temp_valid,
   input  wire logic [15:0] i_temp_value,
   output logic             o_sda_o,
   output logic             o_sda_oe,
   output logic [15:0]      o_temperature_result,
   output logic [15:0]      o_sensor_config,
   output logic [15:0]      o_low_limit,
   output logic [15:0]      o_high_limit,
   output logic [1:0]       o_register_select,
   output logic             o_read_busy
);

   // ==========================================================
   // state
   typedef struct packed {
      logic [1:0]  sel;
      logic [15:0] temp;
      logic        pend_v;
      logic [15:0] pend;
      logic [15:0] cfg;
      logic [15:0] low;
      logic [15:0] high;
      logic [1:0]  wr_idx;
      logic [7:0]  lim_hi;
      logic        rd_hi;
      logic [15:0] rd_word;
      logic [15:0] last_word;
      logic        busy;
   } tsr_regs_q_s;

   tsr_regs_q_s           q;
   tsr_regs_q_s           d;
   tsr_pkg::tsr_link_ev_s ev;
   logic [15:0]           mask;
   logic [15:0]           cur_word;
   logic [7:0]            rd_data;
   logic                  wr_ack;
   logic [2:0]            res_shift;

   // ==========================================================
   // serial link
   tsr_link u_link (
      .i_core_clk           (i_core_clk),
      .i_rst_n              (i_rst_n),
      .i_scl                (i_scl),
      .i_sda_i              (i_sda_i),
      .i_strap_address_pins (i_strap_address_pins),
      .i_wr_ack             (wr_ack),
      .i_rd_data            (rd_data),
      .o_sda_o              (o_sda_o),
      .o_sda_oe             (o_sda_oe),
      .o_ev                 (ev)
   );

   // ==========================================================
   // read data and answers
   always_comb
   begin
      res_shift = tsr_pkg::RES_9BIT_SHIFT
                  - {1'b0, q.cfg[tsr_pkg::CFG_RES_LSB +: 2]};
      mask      = 16'hffff << res_shift;
      unique case (q.sel)
         tsr_pkg::REG_TEMP:
         begin
            cur_word = q.pend_v ? q.pend : q.temp;
         end
         tsr_pkg::REG_CONFIG:
         begin
            cur_word = q.cfg & tsr_pkg::CFG_READ_MASK;
         end
         tsr_pkg::REG_LOW:
         begin
            cur_word = q.low;
         end
         tsr_pkg::REG_HIGH:
         begin
            cur_word = q.high;
         end
      endcase
      rd_data = q.rd_hi ? cur_word[15:8] : q.rd_word[7:0];
      wr_ack  = !(q.wr_idx != tsr_pkg::WR_IDX_SELECT
                  && q.sel == tsr_pkg::REG_TEMP);
   end

   // ==========================================================
   // next state
   always_comb
   begin
      d = q;
      d.last_word = cur_word;
      if (ev.start_wr)
      begin
         d.wr_idx = tsr_pkg::WR_IDX_SELECT;
      end
      if (ev.start_rd)
      begin
         d.rd_hi = 1'b1;
      end
      if (ev.rd_req)
      begin
         if (q.rd_hi)
         begin
            d.rd_word = q.last_word;
            d.rd_hi   = 1'b0;
            if (q.sel == tsr_pkg::REG_TEMP)
            begin
               d.busy = 1'b1;
               if (q.pend_v)
               begin
                  d.temp   = q.pend;
                  d.pend_v = 1'b0;
               end
            end
         end
         else
         begin
            d.rd_hi = 1'b1;
         end
      end
      if (ev.stop || ev.start_rd || ev.start_wr
         || (ev.mst_ack_valid && !ev.mst_ack))
      begin
         d.busy = 1'b0;
      end
      if (ev.wr_valid)
      begin
         unique case (q.wr_idx)
            tsr_pkg::WR_IDX_SELECT:
            begin
               if (ev.wr_data[7:2] == 6'h00)
               begin
                  d.sel = ev.wr_data[1:0];
               end
               d.wr_idx = tsr_pkg::WR_IDX_MSB;
            end
            tsr_pkg::WR_IDX_MSB:
            begin
               if (q.sel == tsr_pkg::REG_CONFIG)
               begin
                  d.cfg = {ev.wr_data, 8'h00};
               end
               d.lim_hi = ev.wr_data;
               d.wr_idx = tsr_pkg::WR_IDX_LSB;
            end
            tsr_pkg::WR_IDX_LSB:
            begin
               if (q.sel == tsr_pkg::REG_LOW)
               begin
                  d.low = {q.lim_hi, ev.wr_data};
               end
               if (q.sel == tsr_pkg::REG_HIGH)
               begin
                  d.high = {q.lim_hi, ev.wr_data};
               end
               d.wr_idx = tsr_pkg::WR_IDX_EXTRA;
            end
            tsr_pkg::WR_IDX_EXTRA:
            begin
               d.wr_idx = tsr_pkg::WR_IDX_EXTRA;
            end
         endcase
      end
      if (!q.busy && q.pend_v)
      begin
         d.temp   = q.pend;
         d.pend_v = 1'b0;
      end
      if (i_temp_valid)
      begin
         if (q.busy)
         begin
            d.pend   = i_temp_value & mask;
            d.pend_v = 1'b1;
         end
         else
         begin
            d.temp   = i_temp_value & mask;
            d.pend_v = 1'b0;
         end
      end
      if (!i_rst_n)
      begin
         d      = '0;
         d.sel  = tsr_pkg::SELECT_RESET;
         d.temp = tsr_pkg::TEMP_RESET;
         d.cfg  = tsr_pkg::CONFIG_RESET;
         d.low  = tsr_pkg::LOW_RESET;
         d.high = tsr_pkg::HIGH_RESET;
         d.rd_hi = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      q <= d;
   end

   assign o_temperature_result = q.temp;
   assign o_sensor_config      = q.cfg;
   assign o_low_limit          = q.low;
   assign o_high_limit         = q.high;
   assign o_register_select    = q.sel;
   assign o_read_busy          = q.busy;

   // ==========================================================
   // checks
   property p_sel_reset;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      !$past(i_rst_n) |-> (q.sel == tsr_pkg::REG_TEMP && q.temp == 16'h0000);
   endproperty
   a_sel_reset: assert property (p_sel_reset)
      else $error("select or temperature not reset");

   property p_low_decode;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (ev.rd_req && q.rd_hi && q.sel == tsr_pkg::REG_LOW)
      |=> q.rd_word == $past(q.low);
   endproperty
   a_low_decode: assert property (p_low_decode)
      else $error("select code 2 did not read low limit");

   property p_bad_select;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (ev.wr_valid && q.wr_idx == tsr_pkg::WR_IDX_SELECT
       && ev.wr_data[7:2] != 6'h00) |=> $stable(q.sel);
   endproperty
   a_bad_select: assert property (p_bad_select)
      else $error("invalid select byte changed select");

   property p_select_hold;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      !(ev.wr_valid && q.wr_idx == tsr_pkg::WR_IDX_SELECT) |=> $stable(q.sel);
   endproperty
   a_select_hold: assert property (p_select_hold)
      else $error("select changed without select write");

   property p_first_byte;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      ev.start_wr |=> q.wr_idx == tsr_pkg::WR_IDX_SELECT;
   endproperty
   a_first_byte: assert property (p_first_byte)
      else $error("write did not restart at select byte");

   property p_temp_nack;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (ev.wr_valid && q.wr_idx != tsr_pkg::WR_IDX_SELECT
       && q.sel == tsr_pkg::REG_TEMP) |=> (!o_sda_oe && $stable(q.temp))
                                         || $past(i_temp_valid)
                                         || $past(q.pend_v);
   endproperty
   a_temp_nack: assert property (p_temp_nack)
      else $error("temperature data write acknowledged or stored");

   property p_busy_hold;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (q.busy && i_temp_valid && !ev.rd_req) |=> $stable(q.temp);
   endproperty
   a_busy_hold: assert property (p_busy_hold)
      else $error("temperature changed during a read");

   property p_res_mask;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_temp_valid && !q.busy) |=> (q.temp & ~$past(mask)) == 16'h0000;
   endproperty
   a_res_mask: assert property (p_res_mask)
      else $error("unused low temperature bits not zero");

   property p_cfg_byte;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (ev.wr_valid && q.wr_idx == tsr_pkg::WR_IDX_MSB
       && q.sel == tsr_pkg::REG_CONFIG)
      |=> q.cfg == {$past(ev.wr_data), 8'h00};
   endproperty
   a_cfg_byte: assert property (p_cfg_byte)
      else $error("config upper byte not stored");

   property p_nack_release;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (ev.mst_ack_valid && !ev.mst_ack) |=> !q.busy ##[1:40] !o_sda_oe;
   endproperty
   a_nack_release: assert property (p_nack_release)
      else $error("nack did not end the read");

   property p_reread;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (ev.rd_req && !q.rd_hi) |=> q.rd_hi;
   endproperty
   a_reread: assert property (p_reread)
      else $error("read did not wrap to upper byte");

   property p_select_ack;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (ev.wr_valid && q.wr_idx == tsr_pkg::WR_IDX_SELECT) |=> o_sda_oe;
   endproperty
   a_select_ack: assert property (p_select_ack)
      else $error("select byte not acknowledged");

   property p_high_write;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (ev.wr_valid && q.wr_idx == tsr_pkg::WR_IDX_LSB
       && q.sel == tsr_pkg::REG_HIGH)
      |=> q.high == {$past(q.lim_hi), $past(ev.wr_data)};
   endproperty
   a_high_write: assert property (p_high_write)
      else $error("high limit not written as a full word");

   property p_temp_ro;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (!i_temp_valid && !q.pend_v) |=> $stable(q.temp);
   endproperty
   a_temp_ro: assert property (p_temp_ro)
      else $error("temperature changed without a conversion");

   property p_cfg_read;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (ev.rd_req && q.rd_hi && q.sel == tsr_pkg::REG_CONFIG)
      |=> q.rd_word[15] == 1'b0 && q.rd_word[7:0] == 8'h00;
   endproperty
   a_cfg_read: assert property (p_cfg_read)
      else $error("config read showed one-shot or low byte");

endmodule
`default_nettype wire

// *** core/tsr_pkg.sv ***
`default_nettype none
package tsr_pkg;

   // ==========================================================
   // register select codes and reset values
   localparam logic [1:0]  REG_TEMP       = 2'h0;
   localparam logic [1:0]  REG_CONFIG     = 2'h1;
   localparam logic [1:0]  REG_LOW        = 2'h2;
   localparam logic [1:0]  REG_HIGH       = 2'h3;
   localparam logic [1:0]  SELECT_RESET   = 2'h0;
   localparam logic [15:0] TEMP_RESET     = 16'h0000;
   localparam logic [15:0] CONFIG_RESET   = 16'h0000;
   localparam logic [15:0] LOW_RESET      = 16'h4b00;
   localparam logic [15:0] HIGH_RESET     = 16'h5000;

   // ==========================================================
   // configuration fields
   localparam int          CFG_RES_LSB    = 13;
   localparam logic [15:0] CFG_READ_MASK  = 16'h7f00;
   localparam logic [2:0]  RES_9BIT_SHIFT = 3'h7;

   // ==========================================================
   // serial link constants
   localparam logic [3:0]  ADDR_PREFIX    = 4'h9;
   localparam logic [3:0]  BYTE_BITS      = 4'h8;
   localparam logic [1:0]  WR_IDX_SELECT  = 2'h0;
   localparam logic [1:0]  WR_IDX_MSB     = 2'h1;
   localparam logic [1:0]  WR_IDX_LSB     = 2'h2;
   localparam logic [1:0]  WR_IDX_EXTRA   = 2'h3;

   typedef enum logic [2:0] {
      TSR_LK_IDLE,
      TSR_LK_ADDR,
      TSR_LK_ADDR_ACK,
      TSR_LK_WR_BYTE,
      TSR_LK_WR_ACK,
      TSR_LK_RD_BYTE,
      TSR_LK_RD_ACK
   } tsr_link_st_e;

   typedef struct packed {
      logic       start_rd;
      logic       start_wr;
      logic       wr_valid;
      logic [7:0] wr_data;
      logic       rd_req;
      logic       mst_ack_valid;
      logic       mst_ack;
      logic       stop;
   } tsr_link_ev_s;

endpackage
`default_nettype wire

// *** core/tsr_link.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsr_link (
   input  wire logic                  i_core_clk,
   input  wire logic                  i_rst_n,
   input  wire logic                  i_scl,
   input  wire logic                  i_sda_i,
   input  wire logic [2:0]            i_strap_address_pins,
   input  wire logic                  i_wr_ack,
   input  wire logic [7:0]            i_rd_data,
   output logic                       o_sda_o,
   output logic                       o_sda_oe,
   output tsr_pkg::tsr_link_ev_s      o_ev
);

   // ==========================================================
   // state
   typedef struct packed {
      logic [1:0]             scl_s;
      logic [1:0]             sda_s;
      logic [5:0]             adr_s;
      logic                   scl_p;
      logic                   sda_p;
      tsr_pkg::tsr_link_st_e  st;
      logic [3:0]             cnt;
      logic [7:0]             sh;
      logic                   rw;
      logic                   acked;
      logic                   oe;
      tsr_pkg::tsr_link_ev_s  ev;
   } tsr_link_q_s;

   tsr_link_q_s q;
   tsr_link_q_s d;
   logic        rise;
   logic        fall;
   logic        start;
   logic        stop;

   // ==========================================================
   // next state
   always_comb
   begin
      d         = q;
      d.ev      = '0;
      d.scl_s   = {q.scl_s[0], i_scl};
      d.sda_s   = {q.sda_s[0], i_sda_i};
      d.adr_s   = {q.adr_s[2:0], i_strap_address_pins};
      d.scl_p   = q.scl_s[1];
      d.sda_p   = q.sda_s[1];
      rise      = q.scl_s[1] & ~q.scl_p;
      fall      = ~q.scl_s[1] & q.scl_p;
      start     = q.scl_s[1] & q.scl_p & q.sda_p & ~q.sda_s[1];
      stop      = q.scl_s[1] & q.scl_p & ~q.sda_p & q.sda_s[1];
      if (start)
      begin
         d.st  = tsr_pkg::TSR_LK_ADDR;
         d.cnt = '0;
         d.oe  = 1'b0;
      end
      else if (stop)
      begin
         d.ev.stop = (q.st != tsr_pkg::TSR_LK_IDLE);
         d.st      = tsr_pkg::TSR_LK_IDLE;
         d.oe      = 1'b0;
      end
      else if (rise)
      begin
         if (q.st == tsr_pkg::TSR_LK_ADDR || q.st == tsr_pkg::TSR_LK_WR_BYTE)
         begin
            d.sh  = {q.sh[6:0], q.sda_s[1]};
            d.cnt = q.cnt + 4'h1;
         end
         else if (q.st == tsr_pkg::TSR_LK_RD_ACK)
         begin
            d.acked            = ~q.sda_s[1];
            d.ev.mst_ack_valid = 1'b1;
            d.ev.mst_ack       = ~q.sda_s[1];
         end
      end
      else if (fall)
      begin
         unique case (q.st)
            tsr_pkg::TSR_LK_ADDR:
            begin
               if (q.cnt == tsr_pkg::BYTE_BITS)
               begin
                  if (q.sh[7:1] == {tsr_pkg::ADDR_PREFIX, q.adr_s[5:3]})
                  begin
                     d.st          = tsr_pkg::TSR_LK_ADDR_ACK;
                     d.oe          = 1'b1;
                     d.rw          = q.sh[0];
                     d.ev.start_rd = q.sh[0];
                     d.ev.start_wr = ~q.sh[0];
                  end
                  else
                  begin
                     d.st = tsr_pkg::TSR_LK_IDLE;
                  end
               end
            end
            tsr_pkg::TSR_LK_ADDR_ACK,
            tsr_pkg::TSR_LK_RD_ACK:
            begin
               d.cnt = 4'h0;
               d.oe  = 1'b0;
               if ((q.st == tsr_pkg::TSR_LK_ADDR_ACK && q.rw)
                  || (q.st == tsr_pkg::TSR_LK_RD_ACK && q.acked))
               begin
                  d.ev.rd_req = 1'b1;
                  d.sh        = i_rd_data;
                  d.oe        = ~i_rd_data[7];
                  d.cnt       = 4'h1;
                  d.st        = tsr_pkg::TSR_LK_RD_BYTE;
               end
               else if (q.st == tsr_pkg::TSR_LK_ADDR_ACK)
               begin
                  d.st = tsr_pkg::TSR_LK_WR_BYTE;
               end
               else
               begin
                  d.st = tsr_pkg::TSR_LK_IDLE;
               end
            end
            tsr_pkg::TSR_LK_RD_BYTE:
            begin
               if (q.cnt == tsr_pkg::BYTE_BITS)
               begin
                  d.oe = 1'b0;
                  d.st = tsr_pkg::TSR_LK_RD_ACK;
               end
               else
               begin
                  d.sh  = {q.sh[6:0], 1'b0};
                  d.oe  = ~q.sh[6];
                  d.cnt = q.cnt + 4'h1;
               end
            end
            tsr_pkg::TSR_LK_WR_BYTE:
            begin
               if (q.cnt == tsr_pkg::BYTE_BITS)
               begin
                  d.ev.wr_valid = 1'b1;
                  d.ev.wr_data  = q.sh;
                  d.oe          = i_wr_ack;
                  d.cnt         = 4'h0;
                  d.st          = tsr_pkg::TSR_LK_WR_ACK;
               end
            end
            tsr_pkg::TSR_LK_WR_ACK:
            begin
               d.oe = 1'b0;
               d.st = tsr_pkg::TSR_LK_WR_BYTE;
            end
            tsr_pkg::TSR_LK_IDLE:
            begin
               d.oe = 1'b0;
            end
            default:
            begin
               d.oe = 1'b0;
               d.st = tsr_pkg::TSR_LK_IDLE;
            end
         endcase
      end
      if (!i_rst_n)
      begin
         d       = '0;
         d.scl_s = 2'h3;
         d.sda_s = 2'h3;
         d.scl_p = 1'b1;
         d.sda_p = 1'b1;
         d.st    = tsr_pkg::TSR_LK_IDLE;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      q <= d;
   end

   assign o_sda_o  = 1'b0;
   assign o_sda_oe = q.oe;
   assign o_ev     = q.ev;

endmodule
`default_nettype wire

// *** testbench/tsr_bus_master.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bus master model: open drain data, clock still between frames
module tsr_bus_master (
   input  wire logic i_link_clk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_pull
);
   logic in_frame;

   initial
   begin
      o_scl      = 1'b1;
      o_sda_pull = 1'b0;
      in_frame   = 1'b0;
   end

   // one bit: drive low phase, raise clock, sample halfway through high phase
   task automatic xfer(input logic b, output logic r);
      @(posedge i_link_clk) o_scl <= 1'b0;
      @(posedge i_link_clk) o_sda_pull <= ~b;
      @(posedge i_link_clk) o_scl <= 1'b1;
      @(posedge i_link_clk) r = i_sda;
   endtask

   task automatic start();
      if (in_frame)
      begin
         @(posedge i_link_clk) o_scl <= 1'b0;
         @(posedge i_link_clk) o_sda_pull <= 1'b0;
         @(posedge i_link_clk) o_scl <= 1'b1;
      end
      @(posedge i_link_clk) o_sda_pull <= 1'b1;
      in_frame = 1'b1;
   endtask

   task automatic stop();
      @(posedge i_link_clk) o_scl <= 1'b0;
      @(posedge i_link_clk) o_sda_pull <= 1'b1;
      @(posedge i_link_clk) o_scl <= 1'b1;
      @(posedge i_link_clk) o_sda_pull <= 1'b0;
      in_frame = 1'b0;
   endtask

   // byte out, msb first, then the device answers on the ninth bit
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         xfer(d[i], r);
      xfer(1'b1, r);
      ack = ~r;
   endtask

   task automatic recv_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         xfer(1'b1, d[i]);
      xfer(~ack, r);
   endtask
endmodule
`default_nettype wire

// *** testbench/test_temp_sensor_register_access.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_temp_sensor_register_access;
   localparam logic [2:0] STRAP = 3'h5;
   logic        core_clk, link_clk, rst_n, temp_valid, scl, pull;
   logic        sda_oe, sda_o, busy;
   logic [15:0] temp_value, temp_q, cfg_q, low_q, high_q, w;
   logic [1:0]  sel_q;
   int          num_errors, checked;
   wire         sda = ~(pull | sda_oe);

   tsr_regs tsr_regs_inst (
      .i_core_clk(core_clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda_i(sda),
      .i_strap_address_pins(STRAP), .i_temp_valid(temp_valid),
      .i_temp_value(temp_value), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
      .o_temperature_result(temp_q), .o_sensor_config(cfg_q),
      .o_low_limit(low_q), .o_high_limit(high_q),
      .o_register_select(sel_q), .o_read_busy(busy));
   tsr_bus_master tsr_bus_master_inst (
      .i_link_clk(link_clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));

   // ==========================================================
   // shared tasks
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task close_out;
      $display("counts: %0d checks, %0d errors", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task open(input logic rd_n, input logic [2:0] strap, input logic exp);
      logic a;
      tsr_bus_master_inst.start();
      tsr_bus_master_inst.send_byte({tsr_pkg::ADDR_PREFIX, strap, rd_n}, a);
      chk({15'h0, a}, {15'h0, exp});
   endtask

   task wr(input logic [7:0] sel, input logic [15:0] d, input int n,
           input logic exp);
      logic a;
      open(1'b0, STRAP, 1'b1);
      tsr_bus_master_inst.send_byte(sel, a);
      chk({15'h0, a}, 16'h0001);
      for (int i = 0; i < n; i++)
      begin
         tsr_bus_master_inst.send_byte(i == 0 ? d[15:8] : d[7:0], a);
         chk({15'h0, a}, {15'h0, exp});
      end
      tsr_bus_master_inst.stop();
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
   endtask

   // second byte after a nack reads the released, pulled-up line
   task rd(input logic full, output logic [15:0] d);
      open(1'b1, STRAP, 1'b1);
      tsr_bus_master_inst.recv_byte(full, d[15:8]);
      tsr_bus_master_inst.recv_byte(1'b0, d[7:0]);
      tsr_bus_master_inst.stop();
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
   endtask

   task conv(input logic [15:0] v);
      @(posedge core_clk);
      temp_value <= v;
      temp_valid <= 1'b1;
      @(posedge core_clk);
      temp_valid <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask

   // ==========================================================
   // scenarios
   task t_reset;
      chk({14'h0, sel_q}, 16'h0000);
      chk(temp_q, 16'h0000);
      chk(cfg_q, 16'h0000);
      chk(low_q, 16'h4b00);
      chk(high_q, 16'h5000);
      chk({15'h0, sda_o}, 16'h0000);
      rd(1'b1, w);
      chk(w, 16'h0000);
      $display("done t_reset");
   endtask

   task t_limits;
      logic a;
      wr(8'h02, 16'h1234, 2, 1'b1);
      wr(8'h03, 16'hf5e0, 2, 1'b1);
      chk(low_q, 16'h1234);
      chk(high_q, 16'hf5e0);
      wr(8'h02, 16'h0000, 0, 1'b1);
      rd(1'b1, w);
      chk(w, 16'h1234);
      wr(8'h03, 16'h0000, 0, 1'b1);
      rd(1'b1, w);
      rd(1'b1, w);
      chk(w, 16'hf5e0);
      wr(8'h04, 16'h0000, 0, 1'b1);
      chk({14'h0, sel_q}, 16'h0003);
      open(1'b1, ~STRAP, 1'b0);
      tsr_bus_master_inst.stop();
      $display("done t_limits");
   endtask

   task t_config;
      logic [15:0] cv;
      for (int c = 0; c < 4; c++)
      begin
         cv = {1'b0, c[1:0], 13'h0000};
         wr(8'h01, cv, 1, 1'b1);
         chk(cfg_q, cv);
         rd(1'b0, w);
         chk(w, {cv[15:8], 8'hff});
         wr(8'h00, 16'h0000, 0, 1'b1);
         conv(16'h9abf);
         rd(1'b1, w);
         chk(w, 16'h9abf & (16'hffff << (7 - c)));
      end
      $display("done t_config");
   endtask

   task t_temp_ro;
      wr(8'h00, 16'h1234, 2, 1'b0);
      chk(temp_q, 16'h9abf & 16'hfff0);
      $display("done t_temp_ro");
   endtask

   task t_hold;
      conv(16'h1940);
      open(1'b1, STRAP, 1'b1);
      tsr_bus_master_inst.recv_byte(1'b1, w[15:8]);
      chk({15'h0, busy}, 16'h0001);
      conv(16'he7c0);
      @(negedge core_clk);
      chk(temp_q, 16'h1940);
      tsr_bus_master_inst.recv_byte(1'b1, w[7:0]);
      chk(w, 16'h1940);
      tsr_bus_master_inst.recv_byte(1'b1, w[15:8]);
      tsr_bus_master_inst.recv_byte(1'b0, w[7:0]);
      chk(w, 16'he7c0);
      tsr_bus_master_inst.stop();
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      chk(temp_q, 16'he7c0);
      $display("done t_hold");
   endtask

   // ==========================================================
   // clocks, watchdog and main sequence
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   initial
   begin
      link_clk = 1'b0;
      #3;
      forever #40 link_clk = ~link_clk;
   end

   initial
   begin
      #600_000;
      num_errors++;
      close_out();
   end

   initial
   begin
      rst_n      = 1'b0;
      temp_valid = 1'b0;
      temp_value = 16'h0000;
      num_errors = 0;
      checked    = 0;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge core_clk);
      t_reset();
      t_limits();
      t_config();
      t_temp_ro();
      t_hold();
      close_out();
   end
endmodule
`default_nettype wire
